// *** rtl/suspend_summary_flag_gate_defs.vh ***
// opcode, operation-kind and timing constants for the suspend admission gate
`ifndef SUSPEND_SUMMARY_FLAG_GATE_DEFS_VH
`define SUSPEND_SUMMARY_FLAG_GATE_DEFS_VH
// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OP_READ_03      8'h03
`define OP_READ_0B      8'h0b
`define OP_READ_3B      8'h3b
`define OP_READ_6B      8'h6b
`define OP_READ_EB      8'heb
`define OP_READ_E7      8'he7
`define OP_ERASE_4K     8'h20
`define OP_ERASE_32K    8'h52
`define OP_ERASE_64K    8'hd8
`define OP_CHIP_ER_A    8'h60
`define OP_CHIP_ER_B    8'hc7
`define OP_PROG_A       8'h02
`define OP_PROG_B       8'ha2
`define OP_PROG_C       8'h32
`define OP_SEQ_PROG_A   8'had
`define OP_SEQ_PROG_B   8'haf
`define OP_SUSPEND_A    8'h75
`define OP_SUSPEND_B    8'hb0
`define OP_RESUME_A     8'h7a
`define OP_RESUME_B     8'hd0
`define OP_WREN         8'h06
`define OP_WRDI         8'h04
`define OP_VWREN        8'h50
`define OP_LOCK_BLK     8'h36
`define OP_UNLOCK_BLK   8'h39
`define OP_LOCK_ALL     8'h7e
`define OP_UNLOCK_ALL   8'h98
`define OP_LOCK_RD_A    8'h3c
`define OP_LOCK_RD_B    8'h3d
`define OP_OTP_PROG     8'h9b
`define OP_OTP_READ     8'h4b
`define OP_SR_RD_1      8'h05
`define OP_SR_RD_2      8'h35
`define OP_SR_RD_3      8'h15
`define OP_SR_RD_IND    8'h65
`define OP_SR_WR_1      8'h01
`define OP_SR_WR_2      8'h31
`define OP_SR_WR_3      8'h11
`define OP_SR_WR_IND    8'h71
`define OP_SR_LOCK      8'h6f
`define OP_TERMINATE    8'hf0
`define OP_RST_EN       8'h66
`define OP_RST_DEV      8'h99
`define OP_ID_A         8'h9f
`define OP_ID_B         8'h90
`define OP_ID_C         8'h94
`define OP_DPD          8'hb9
`define OP_DPD_EXIT     8'hab
`define OP_UDPD         8'h79
`define OP_SFDP         8'h5a
`define OP_WRAP         8'h77
// ----------------------------------------------------------------------
// operation kinds reported with an accepted opcode
// ----------------------------------------------------------------------
`define KIND_W          3
`define KIND_OTHER      3'h0
`define KIND_ERASE      3'h1
`define KIND_PROG       3'h2
`define KIND_NOSUSP     3'h3
`define KIND_SUSPEND    3'h4
`define KIND_RESUME     3'h5
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   8
`define SUSPEND_SUMMARY_FLAG_LAT_NS     20000
`define SUSPEND_SUMMARY_FLAG_LAT_CYC    (`SUSPEND_SUMMARY_FLAG_LAT_NS / `CLK_PERIOD_NS)
`endif

// *** rtl/opcode_classifier.v ***
// opcode admission table for busy and suspend states
`timescale 1ns/1ps
`include "suspend_summary_flag_gate_defs.vh"
module opcode_classifier (
    input  wire [7:0]  opcode,
    input  wire        busy,
    input  wire        prog_suspend_summary_flag,
    input  wire        erase_suspend_summary_flag,
    output reg         allowed,
    output reg  [2:0]  kind
);
    reg idle_ok;
    reg suspend_summary_flag_ok;
    reg busy_ok;
    reg never_ok;
    always @* begin
        idle_ok  = 1'b0;
        suspend_summary_flag_ok  = 1'b0;
        busy_ok  = 1'b0;
        never_ok = 1'b0;
        kind     = `KIND_OTHER;
        case (opcode)
            `OP_SR_RD_1, `OP_SR_RD_2, `OP_SR_RD_3, `OP_SR_RD_IND,
            `OP_TERMINATE, `OP_RST_EN, `OP_RST_DEV, `OP_ID_A,
            `OP_ID_B, `OP_ID_C, `OP_DPD_EXIT: begin
                busy_ok = 1'b1;
                suspend_summary_flag_ok = 1'b1;
            end
            `OP_SUSPEND_A, `OP_SUSPEND_B: begin
                busy_ok = 1'b1;
                kind    = `KIND_SUSPEND;
            end
            `OP_RESUME_A, `OP_RESUME_B: begin
                suspend_summary_flag_ok = 1'b1;
                kind    = `KIND_RESUME;
            end
            `OP_WREN, `OP_WRDI, `OP_VWREN, `OP_LOCK_RD_A, `OP_LOCK_RD_B,
            `OP_OTP_READ, `OP_SFDP, `OP_WRAP, `OP_READ_03, `OP_READ_0B,
            `OP_READ_3B, `OP_READ_6B, `OP_READ_EB, `OP_READ_E7: begin
                suspend_summary_flag_ok = 1'b1;
                idle_ok = 1'b1;
            end
            `OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K: begin
                idle_ok = 1'b1;
                kind    = `KIND_ERASE;
            end
            `OP_CHIP_ER_A, `OP_CHIP_ER_B: begin
                idle_ok = 1'b1;
                kind    = `KIND_NOSUSP;
            end
            `OP_PROG_A, `OP_PROG_B, `OP_PROG_C: begin
                idle_ok = 1'b1;
                kind    = `KIND_PROG;
            end
            `OP_SEQ_PROG_A, `OP_SEQ_PROG_B: begin
                idle_ok = 1'b1;
                kind    = `KIND_NOSUSP;
            end
            `OP_SR_WR_1, `OP_SR_WR_2, `OP_SR_WR_3, `OP_SR_WR_IND,
            `OP_SR_LOCK, `OP_OTP_PROG: begin
                never_ok = 1'b1;
                kind     = `KIND_NOSUSP;
            end
            `OP_LOCK_BLK, `OP_UNLOCK_BLK, `OP_LOCK_ALL, `OP_UNLOCK_ALL,
            `OP_DPD, `OP_UDPD: begin
                never_ok = 1'b1;
            end
            default: begin
                idle_ok = 1'b1;
            end
        endcase
        if (busy)
            allowed = busy_ok;
        else if (prog_suspend_summary_flag)
            allowed = suspend_summary_flag_ok;
        else if (erase_suspend_summary_flag)
            // program may nest inside an erase suspend, erase may not
            allowed = suspend_summary_flag_ok || kind == `KIND_PROG;
        else
            allowed = idle_ok || busy_ok || suspend_summary_flag_ok || never_ok;
        if (never_ok && (busy || prog_suspend_summary_flag || erase_suspend_summary_flag))
            allowed = 1'b0;
    end
endmodule // opcode_classifier

// *** rtl/suspend_gate.v ***
// program/erase suspend admission and status flag control
//
// Summary of operation
// - while busy only status, suspend, terminate, reset, ID, DPD exit pass
// - lock, OTP program, status write/lock, power-down refused when not idle
// - in program suspend accept resume, latch, reads; refuse erase/program
// - in erase suspend accept the same non-modifying and latch opcodes
// - suspend takes effect one suspend latency after the accept, which follows chip select rise by the synchroniser delay
// - completed suspend sets summary flag and program or erase flag
// - completed suspend clears ready_busy_flag
// - status writes, status lock, OTP program cannot be suspended
// - suspend ignored during chip erase, sequential program, non-suspendable
// - program may start and run while erase is suspended
// - nested program completes before suspended erase resumes
// - no erase may start while a program is suspended
// - suspend acts regardless of write_enable_latch
// - two suspend opcodes behave identically
// - refused opcodes do nothing and leave write_enable_latch alone
// - suspend only when chip select rises on an eight-bit boundary
`timescale 1ns/1ps
`include "suspend_summary_flag_gate_defs.vh"
module suspend_gate #(
    parameter SUSPEND_SUMMARY_FLAG_LAT_CYCLES = `SUSPEND_SUMMARY_FLAG_LAT_CYC
) (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        spi_sck,
    input  wire        spi_cs_n,
    input  wire        spi_si,
    input  wire        op_done,
    output reg         ready_busy_flag,
    output reg         program_suspended_flag,
    output reg         erase_suspended_flag,
    output reg         suspend_summary_flag,
    output reg         cmd_accept,
    output reg  [7:0]  cmd_opcode,
    output reg         op_halt,
    output reg         op_resume
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    reg [1:0] sck_sync_reg;
    reg [1:0] cs_sync_reg;
    reg [1:0] si_sync_reg;
    reg       sck_prev_reg;
    reg       cs_prev_reg;
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sck_sync_reg <= 2'b00;
            cs_sync_reg  <= 2'b11;
            si_sync_reg  <= 2'b00;
            sck_prev_reg <= 1'b0;
            cs_prev_reg  <= 1'b1;
        end else begin
            sck_sync_reg <= {sck_sync_reg[0], spi_sck};
            cs_sync_reg  <= {cs_sync_reg[0], spi_cs_n};
            si_sync_reg  <= {si_sync_reg[0], spi_si};
            sck_prev_reg <= sck_sync_reg[1];
            cs_prev_reg  <= cs_sync_reg[1];
        end
    end
    // edges are found a few clocks late; sck phases shorter than one
    // clock can be lost, which caps the link rate
    wire sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
    wire cs_rise  = cs_sync_reg[1] & ~cs_prev_reg;
    wire cs_low   = ~cs_sync_reg[1];

    // ------------------------------------------------------------------
    // opcode shifter; only the first byte of a frame matters here
    // ------------------------------------------------------------------
    reg [7:0] shift_reg;
    reg [2:0] bit_cnt_reg;
    reg       first_done_reg;
    reg       aligned_reg;
    reg [7:0] opcode_reg;
    // misaligned release leaves aligned_reg low so the frame is void
    always @(posedge core_clk) begin
        if (sys_rst) begin
            shift_reg      <= 8'h00;
            bit_cnt_reg    <= 3'h0;
            first_done_reg <= 1'b0;
            aligned_reg    <= 1'b1;
            opcode_reg     <= 8'h00;
        end else if (!cs_low) begin
            bit_cnt_reg    <= 3'h0;
            first_done_reg <= 1'b0;
            aligned_reg    <= 1'b1;
        end else if (sck_rise) begin
            shift_reg   <= {shift_reg[6:0], si_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            aligned_reg <= (bit_cnt_reg == 3'h7);
            if (bit_cnt_reg == 3'h7 && !first_done_reg) begin
                first_done_reg <= 1'b1;
                opcode_reg     <= {shift_reg[6:0], si_sync_reg[1]};
            end
        end
    end

    // ------------------------------------------------------------------
    // admission
    // ------------------------------------------------------------------
    wire       allowed;
    wire [2:0] kind;
    opcode_classifier u_class (
        .opcode     (opcode_reg),
        .busy       (ready_busy_flag),
        .prog_suspend_summary_flag  (program_suspended_flag),
        .erase_suspend_summary_flag (erase_suspended_flag),
        .allowed    (allowed),
        .kind       (kind)
    );
    // a command counts only when cs rises on a byte boundary
    wire frame_ok = cs_rise && first_done_reg && aligned_reg;
    // resume needs something held in suspend
    wire any_suspend_summary_flag = program_suspended_flag | erase_suspended_flag;

    // ------------------------------------------------------------------
    // operation tracking
    // ------------------------------------------------------------------
    localparam RUN_NONE  = 2'd0;
    localparam RUN_ERASE = 2'd1;
    localparam RUN_PROG  = 2'd2;
    localparam RUN_LOCK  = 2'd3; // running but not suspendable
    reg [1:0]  run_reg;
    reg        halt_pend_reg;
    // counter wide enough for any realistic latency setting
    reg [31:0] lat_cnt_reg;
    reg        nested_reg;
    always @(posedge core_clk) begin
        if (sys_rst) begin
            ready_busy_flag        <= 1'b0;
            program_suspended_flag <= 1'b0;
            erase_suspended_flag   <= 1'b0;
            suspend_summary_flag   <= 1'b0;
            cmd_accept             <= 1'b0;
            cmd_opcode             <= 8'h00;
            op_halt                <= 1'b0;
            op_resume              <= 1'b0;
            run_reg                <= RUN_NONE;
            halt_pend_reg          <= 1'b0;
            lat_cnt_reg            <= 32'h0;
            nested_reg             <= 1'b0;
        end else begin
            cmd_accept <= 1'b0;
            op_halt    <= 1'b0;
            op_resume  <= 1'b0;
            // frames landing during a pending halt or a completion cycle
            // are dropped; the host is expected to poll status first
            if (halt_pend_reg) begin
                // halt completes SUSPEND_SUMMARY_FLAG_LAT_CYCLES cycles after the accept
                if (lat_cnt_reg >= SUSPEND_SUMMARY_FLAG_LAT_CYCLES - 1) begin
                    halt_pend_reg   <= 1'b0;
                    op_halt         <= 1'b1;
                    ready_busy_flag <= 1'b0;
                    suspend_summary_flag <= 1'b1;
                    if (run_reg == RUN_PROG)
                        program_suspended_flag <= 1'b1;
                    else
                        erase_suspended_flag <= 1'b1;
                    run_reg <= RUN_NONE;
                end else begin
                    lat_cnt_reg <= lat_cnt_reg + 32'h1;
                end
            end else if (ready_busy_flag && op_done) begin
                ready_busy_flag <= 1'b0;
                run_reg         <= RUN_NONE;
                if (nested_reg && !program_suspended_flag)
                    nested_reg <= 1'b0;
            end else if (frame_ok && allowed) begin
                cmd_accept <= 1'b1;
                cmd_opcode <= opcode_reg;
                case (kind)
                    `KIND_SUSPEND: begin
                        // no write-enable check on purpose
                        if (run_reg == RUN_ERASE ||
                            run_reg == RUN_PROG) begin
                            halt_pend_reg <= 1'b1;
                            lat_cnt_reg   <= 32'h0;
                        end
                    end
                    `KIND_RESUME: begin
                        // with nothing held, resume is only acknowledged
                        if (any_suspend_summary_flag) begin
                            op_resume       <= 1'b1;
                            ready_busy_flag <= 1'b1;
                            // program resumes first in a double suspend
                            if (program_suspended_flag) begin
                                program_suspended_flag <= 1'b0;
                                run_reg <= RUN_PROG;
                                if (!erase_suspended_flag)
                                    suspend_summary_flag <= 1'b0;
                            end else begin
                                erase_suspended_flag <= 1'b0;
                                suspend_summary_flag <= 1'b0;
                                run_reg <= RUN_ERASE;
                            end
                        end
                    end
                    `KIND_ERASE: begin
                        ready_busy_flag <= 1'b1;
                        run_reg         <= RUN_ERASE;
                    end
                    `KIND_PROG: begin
                        ready_busy_flag <= 1'b1;
                        run_reg         <= RUN_PROG;
                        nested_reg      <= erase_suspended_flag;
                    end
                    `KIND_NOSUSP: begin
                        ready_busy_flag <= 1'b1;
                        run_reg         <= RUN_LOCK;
                    end
                    default: begin
                        run_reg <= run_reg;
                    end
                endcase
            end
        end
    end
endmodule // suspend_gate

// *** verification/suspend_summary_flag_gate_monitor.sv ***
// port-level checker for the suspend admission gate
`timescale 1ns/1ps
module suspend_summary_flag_gate_monitor #(
    parameter SUSPEND_SUMMARY_FLAG_LAT_CYCLES = 4
) (
    input logic       core_clk,
    input logic       sys_rst,
    input logic       ready_busy_flag,
    input logic       program_suspended_flag,
    input logic       erase_suspended_flag,
    input logic       suspend_summary_flag,
    input logic       cmd_accept,
    input logic [7:0] cmd_opcode,
    input logic       op_halt,
    input logic       op_resume
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    halt_effect_a:
        assert property (op_halt |-> !ready_busy_flag && suspend_summary_flag
            && (program_suspended_flag || erase_suspended_flag))
        else $error("halt without flag update");
    halt_latency_a:
        assert property (op_halt |-> $past(cmd_accept, SUSPEND_SUMMARY_FLAG_LAT_CYCLES)
            && (cmd_opcode == 8'h75 || cmd_opcode == 8'hb0))
        else $error("halt not at suspend latency");
    busy_admit_a:
        assert property (cmd_accept && $past(ready_busy_flag)
            && $past(ready_busy_flag, 2) |-> cmd_opcode inside {8'h05, 8'h35,
            8'h15, 8'h65, 8'h75, 8'hb0, 8'hf0, 8'h66, 8'h99, 8'h9f, 8'h90,
            8'h94, 8'hab}) else $error("opcode admitted while busy");
    locked_refuse_a:
        assert property (cmd_accept && ($past(ready_busy_flag)
            || $past(program_suspended_flag) || $past(erase_suspended_flag))
            |-> !(cmd_opcode inside {8'h36, 8'h39, 8'h7e, 8'h98, 8'h9b, 8'h01,
            8'h31, 8'h11, 8'h71, 8'h6f, 8'hb9, 8'h79}))
        else $error("modifying opcode admitted while not idle");
    psusp_refuse_a:
        assert property (cmd_accept && $past(program_suspended_flag)
            && !$past(ready_busy_flag) |-> !(cmd_opcode inside {8'h20, 8'h52,
            8'hd8, 8'h60, 8'hc7, 8'h02, 8'ha2, 8'h32, 8'had, 8'haf}))
        else $error("array opcode admitted in program suspend");
    resume_busy_a:
        assert property (op_resume |-> ##[0:1] ready_busy_flag)
        else $error("resume without busy");
    summary_set_a:
        assert property ($rose(program_suspended_flag)
            || $rose(erase_suspended_flag) |-> ##[0:1] suspend_summary_flag)
        else $error("suspend flag without summary");
    accept_pulse_a:
        assert property (cmd_accept |=> !cmd_accept)
        else $error("accept longer than one cycle");
    cover property (op_halt);
    cover property (program_suspended_flag && erase_suspended_flag);
    cover property (op_resume);
endmodule // suspend_summary_flag_gate_monitor

bind suspend_gate suspend_summary_flag_gate_monitor #(.SUSPEND_SUMMARY_FLAG_LAT_CYCLES(SUSPEND_SUMMARY_FLAG_LAT_CYCLES))
    u_mon (.core_clk, .sys_rst, .ready_busy_flag, .program_suspended_flag,
    .erase_suspended_flag, .suspend_summary_flag, .cmd_accept, .cmd_opcode,
    .op_halt, .op_resume);

// *** verification/spi_host_model.sv ***
// serial host model issuing one opcode frame per call
`timescale 1ns/1ps
module spi_host_model (
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_si
);
    initial begin
        spi_sck  = 1'b0;
        spi_cs_n = 1'b1;
        spi_si   = 1'b0;
    end
    // clock runs only inside a frame; short counts model a bad release
    task automatic send(input logic [7:0] op, input int nbits);
        #5;
        spi_cs_n = 1'b0;
        for (int i = 7; i > 7 - nbits; i--) begin
            spi_si = op[i];
            #32 spi_sck = 1'b1;
            #32 spi_sck = 1'b0;
        end
        #32 spi_cs_n = 1'b1;
        spi_si = ~spi_si;
    endtask
endmodule // spi_host_model

// *** verification/tb.sv ***
// self-checking bench for the suspend admission gate
`timescale 1ns/1ps
module tb;
    logic       core_clk = 1'b0;
    logic       sys_rst  = 1'b1;
    logic       op_done  = 1'b0;
    wire        spi_sck, spi_cs_n, spi_si;
    wire        ready_busy_flag, program_suspended_flag;
    wire        erase_suspended_flag, suspend_summary_flag;
    wire        cmd_accept, op_halt, op_resume;
    wire [7:0]  cmd_opcode;
    int         errors = 0;
    int         total_checks = 0;
    bit         halted, resumed;
    logic [7:0] busy_ok[] = '{8'h05, 8'h35, 8'h15, 8'h65, 8'h66, 8'h9f,
        8'h90, 8'h94, 8'hab};
    logic [7:0] busy_no[] = '{8'h02, 8'h20, 8'h06, 8'h04, 8'h50, 8'h36,
        8'h9b, 8'h01, 8'h6f, 8'hb9, 8'h79, 8'h5a, 8'h77, 8'h7a, 8'h4b, 8'h03};
    logic [7:0] sus_ok[] = '{8'h06, 8'h04, 8'h50, 8'h3c, 8'h3d, 8'h4b,
        8'h5a, 8'h77, 8'h05, 8'h03};
    logic [7:0] sus_no[] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h36,
        8'h39, 8'h7e, 8'h98, 8'h9b, 8'h01, 8'h31, 8'h11, 8'h71, 8'h6f, 8'hb9,
        8'h79};
    logic [7:0] nosusp[] = '{8'h60, 8'hc7, 8'haf, 8'had, 8'h01, 8'h31,
        8'h11, 8'h71, 8'h6f, 8'h9b};

    always #4 core_clk = ~core_clk;

    spi_host_model host (.spi_sck, .spi_cs_n, .spi_si);
    suspend_gate #(.SUSPEND_SUMMARY_FLAG_LAT_CYCLES(4)) dut (.core_clk, .sys_rst, .spi_sck,
        .spi_cs_n, .spi_si, .op_done, .ready_busy_flag,
        .program_suspended_flag, .erase_suspended_flag, .suspend_summary_flag,
        .cmd_accept, .cmd_opcode, .op_halt, .op_resume);

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // exp order: busy, program suspended, erase suspended, summary
    task automatic flags(input logic [3:0] exp);
        check("flags", {4'h0, ready_busy_flag, program_suspended_flag,
            erase_suspended_flag, suspend_summary_flag}, {4'h0, exp});
    endtask

    // negedge sampling keeps clear of the pulse-launching edge
    task automatic cmd(input logic [7:0] op, input logic exp,
                       input int nbits = 8);
        logic seen;
        seen = 1'b0;
        halted = 1'b0;
        resumed = 1'b0;
        host.send(op, nbits);
        repeat (12) begin
            @(negedge core_clk);
            if (cmd_accept === 1'b1) seen = 1'b1;
            if (op_halt === 1'b1) halted = 1'b1;
            if (op_resume === 1'b1) resumed = 1'b1;
        end
        check("accept", {7'h0, seen}, {7'h0, exp});
        if (exp === 1'b1) check("opcode", cmd_opcode, op);
    endtask

    task automatic done_pulse();
        @(posedge core_clk) op_done <= 1'b1;
        @(posedge core_clk) op_done <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic wrap_up();
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        flags(4'h0);
        cmd(8'h20, 1'b1);
        flags(4'h8);
        foreach (busy_ok[i]) cmd(busy_ok[i], 1'b1);
        foreach (busy_no[i]) cmd(busy_no[i], 1'b0);
        cmd(8'h75, 1'b0, 7);
        flags(4'h8);
        cmd(8'hb0, 1'b1);
        check("halt", {7'h0, halted}, 8'h01);
        flags(4'h3);
        foreach (sus_no[i]) cmd(sus_no[i], 1'b0);
        foreach (sus_ok[i]) cmd(sus_ok[i], 1'b1);
        cmd(8'h02, 1'b1);
        flags(4'hb);
        cmd(8'h75, 1'b1);
        flags(4'h7);
        cmd(8'h20, 1'b0);
        cmd(8'h02, 1'b0);
        cmd(8'h7a, 1'b1);
        check("resume", {7'h0, resumed}, 8'h01);
        flags(4'hb);
        done_pulse();
        flags(4'h3);
        cmd(8'hd0, 1'b1);
        flags(4'h8);
        done_pulse();
        flags(4'h0);
        foreach (nosusp[i]) begin
            cmd(nosusp[i], 1'b1);
            cmd(8'h75, 1'b1);
            check("halt", {7'h0, halted}, 8'h00);
            flags(4'h8);
            done_pulse();
        end
        cmd(8'h32, 1'b1);
        cmd(8'hb0, 1'b1);
        check("halt", {7'h0, halted}, 8'h01);
        flags(4'h5);
        cmd(8'hd8, 1'b0);
        cmd(8'h06, 1'b1);
        cmd(8'hd0, 1'b1);
        flags(4'h8);
        done_pulse();
        flags(4'h0);
        cmd(8'h7a, 1'b1);
        check("resume", {7'h0, resumed}, 8'h00);
        flags(4'h0);
        wrap_up();
    end

    initial begin
        #300000;
        errors++;
        wrap_up();
    end
endmodule // tb
